// ### inc/usc_pkg.sv
// Constants, types and helpers shared by the serial port status block.
// Assumes a single 25 MHz clock domain and APB access with 32-bit data.
//
// Summary of operation
// [R1] Select 00: interrupt on every buffer-to-shifter move
// [R2] Select 01: interrupt when all transmit work done
// [R3] Select 10: interrupt when move empties transmit buffer
// [R4] Software never writes transmit select 11
// [R5] Polarity bit and infrared codec set idle level
// [R6] Break: start, twelve zeros, stop, then self-clear
// [R7] Transmit enable drives pin; clearing aborts and flushes
// [R8] Buffer-full flag shows no room for characters
// [R9] Shift-empty flag: shifter and buffer empty; resets one
// [R10] Select 11: interrupt when buffer reaches four
// [R11] Select 10: interrupt when buffer reaches three
// [R12] Select 0x: interrupt on every received character
// [R13] Address detect only in nine-bit mode, bit8 set
// [R14] Receiver-idle flag high when not receiving; resets one
// [R15] Parity error belongs to character at FIFO head
// [R16] Framing error belongs to character at FIFO head
// [R17] Overrun sets; writing zero flushes buffer and shifter
// [R18] Data-available flag high while buffer holds data
// [R19] Data register read pops head with its flags
// [R20] Parity-and-data select 11 means nine bits, no parity
// [R21] Transmit side buffers four characters before shifter
package usc_pkg;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_MODE    = 8'h00;
  localparam logic [7:0]  OFF_STAT    = 8'h04;
  localparam logic [7:0]  OFF_TXDATA  = 8'h08;
  localparam logic [7:0]  OFF_RXDATA  = 8'h0c;
  localparam int          B_INFRARED_CODEC_ENABLE      = 12;
  localparam int          B_TXISEL1   = 15;
  localparam int          B_TXINV     = 14;
  localparam int          B_TXISEL0   = 13;
  localparam int          B_TXBRK     = 11;
  localparam int          B_TXEN      = 10;
  localparam int          B_ADDRESS_DETECT_ENABLE     = 5;
  localparam int          B_OVERRUN_ERROR      = 1;
  localparam logic [1:0]  ISEL_RST    = 2'h0;
  localparam logic        FLAG_RST0   = 1'b0;
  localparam logic        FLAG_RST1   = 1'b1;

  // ****************************************
  // Mode encodings and counts
  // ****************************************
  localparam logic [1:0]  TXI_ANY     = 2'h0;
  localparam logic [1:0]  TXI_DONE    = 2'h1;
  localparam logic [1:0]  TXI_EMPTY   = 2'h2;
  localparam logic [1:0]  RXI_3Q      = 2'h2;
  localparam logic [1:0]  RXI_FULL    = 2'h3;
  localparam logic [1:0]  PD_EVEN     = 2'h1;
  localparam logic [1:0]  PD_ODD      = 2'h2;
  localparam logic [1:0]  PD_9BIT     = 2'h3;
  localparam int          FIFO_DEPTH  = 4;
  localparam logic [2:0]  RX_TH3      = 3'h3;
  localparam logic [2:0]  RX_TH4      = 3'h4;
  localparam logic [3:0]  SUB_LAST    = 4'hf;
  localparam logic [3:0]  SUB_MID     = 4'h7;
  localparam logic [3:0]  BRK_LEN     = 4'he;
  localparam int          BAUD_DIV_DEF = 13;

  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} usc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010,
                            RX_DATA = 3'b100} usc_rx_st_t;

  // Parity bit for the even and odd modes
  function automatic logic usc_par(input logic [1:0] pd,
                                   input logic [7:0] d);
    usc_par = (pd == PD_ODD) ? ~^d : ^d;
  endfunction : usc_par

  // Frame bits, start first, padded with stop level; length in top nibble
  function automatic logic [18:0] usc_frame(input logic [1:0] pd,
                                            input logic st,
                                            input logic [8:0] d);
    logic [3:0] n;
    n = (pd == 2'h0) ? 4'ha : 4'hb;
    if (pd == PD_9BIT)
      usc_frame = {4'(n + 4'(st)), 5'h1f, d, 1'b0};
    else if (pd == 2'h0)
      usc_frame = {4'(n + 4'(st)), 6'h3f, d[7:0], 1'b0};
    else
      usc_frame = {4'(n + 4'(st)), 5'h1f, usc_par(pd, d[7:0]), d[7:0], 1'b0};
  endfunction : usc_frame

endpackage : usc_pkg

// ### core/usc_fifo.sv
// Small synchronous FIFO with occupancy count and flush.
// Assumes push is never given while full nor pop while empty.
`timescale 1ns/1ns
module usc_fifo #(
  parameter int W = 9,
  parameter int D = 4,
  parameter int CW = $clog2(D + 1)
) (
  input  wire logic          clock,   // System clock
  input  wire logic          reset_n, // Async reset, active low
  input  wire logic          flush,   // Empty the queue
  input  wire logic          push,    // Write din
  input  wire logic [W-1:0]  din,     // Data in
  input  wire logic          pop,     // Drop head
  output logic      [W-1:0]  dout,    // Head entry
  output logic      [CW-1:0] count,   // Occupancy
  output logic               full,    // No room
  output logic               empty    // Nothing stored
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;

  // Storage array; contents need no reset
  always_ff @(posedge clock) begin
    if (push)
      mem[wp_q] <= din;
  end

  // Pointers wrap at the depth
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push)
        wp_q <= (wp_q == AW'(D - 1)) ? '0 : AW'(wp_q + 1'b1);
      if (pop)
        rp_q <= (rp_q == AW'(D - 1)) ? '0 : AW'(rp_q + 1'b1);
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end

  assign dout  = mem[rp_q];
  assign count = cnt_q;
  assign full  = (cnt_q == CW'(D));
  assign empty = (cnt_q == '0);
endmodule : usc_fifo

// ### core/usc_baud.sv
// Oversampling tick source: one pulse every DIV clocks.
// Assumes the divider is fixed for the life of the build.
`timescale 1ns/1ns
module usc_baud #(
  parameter int DIV = 13
) (
  input  wire logic clock,   // System clock
  input  wire logic reset_n, // Async reset, active low
  output logic      tick     // Sixteen ticks per bit
);
  logic [15:0] cnt_q;

  // Free-running divider
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_q == 16'(DIV - 1));
      cnt_q <= (cnt_q == 16'(DIV - 1)) ? '0 : 16'(cnt_q + 1'b1);
    end
  end
endmodule : usc_baud

// ### core/usc_core.sv
// Serial port status and control: APB registers, transmit and receive.
// Assumes synchronous rx pin and a single clock; pin muxing is outside.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
module usc_core #(
  parameter int BAUD_DIV = usc_pkg::BAUD_DIV_DEF
) (
  input  wire logic                      clock,        // 25 MHz clock
  input  wire logic                      reset_n,      // Async, active low
  input  wire logic                      psel,         // APB select
  input  wire logic                      penable,      // APB enable
  input  wire logic                      pwrite,       // APB direction
  input  wire logic [usc_pkg::ADDR_W-1:0] paddr,       // APB address
  input  wire logic [31:0]               pwdata,       // APB write data
  output logic                           pready,       // APB ready
  output logic      [31:0]               prdata,       // APB read data
  output logic                           pslverr,      // Unmapped address
  input  wire logic                      serial_rx_pin, // Line in
  output logic                           serial_tx_pin, // Line out
  output logic                           serial_tx_oe, // Port owns pin
  output logic                           tx_irq,       // Transmit event
  output logic                           rx_irq        // Receive event
);
  import usc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic       ir_en_q, stsel_q, txinv_q, brk_q, txen_q, address_detect_enable_q, overrun_error_q;
  logic [1:0] pdsel_q, txisel_q, rxisel_q;
  logic       tick, done, wr, rd, acc, mapped;
  logic       wr_stat, tx_push, tx_pop, tx_flush, tx_full, tx_empty;
  logic [8:0] tx_head;
  logic [2:0] tx_count, rx_count, rx_next_cnt;
  usc_tx_st_t tx_st_q;
  logic [14:0] tx_vec_q;
  logic [3:0] tx_left_q, tx_sub_q;
  logic       tx_brk_act_q, tx_done;
  logic [18:0] frame;
  usc_rx_st_t rx_st_q;
  logic [3:0] rx_sub_q, rx_idx_q, rx_last;
  logic [8:0] rx_sh_q;
  logic       rx_fin, rx_keep, rx_push, rx_pop, rx_full, rx_empty;
  logic       rx_ovf, rx_clear, nine;
  logic [10:0] rx_head, rx_din;
  logic [15:0] stat;
  logic [31:0] rd_mux;

  usc_baud #(.DIV(BAUD_DIV)) u_baud (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // ****************************************
  // APB slave: answer on the second access cycle
  // ****************************************
  assign acc    = psel & penable & ~pready;
  assign done   = psel & penable & pready;
  assign wr     = done & pwrite;
  assign rd     = done & ~pwrite;
  assign mapped = (paddr == OFF_MODE) | (paddr == OFF_STAT) |
                  (paddr == OFF_TXDATA) | (paddr == OFF_RXDATA);
  assign wr_stat = wr & (paddr == OFF_STAT);

  // Status word, reserved bits read zero
  assign stat = {txisel_q[1], txinv_q, txisel_q[0], 1'b0, brk_q, txen_q,
                 tx_full,                               // R8
                 tx_empty & (tx_st_q == TX_IDLE),       // R9
                 rxisel_q, address_detect_enable_q,
                 rx_st_q == RX_IDLE,                    // R14
                 rx_head[9] & ~rx_empty,                // R15
                 rx_head[10] & ~rx_empty,               // R16
                 overrun_error_q, ~rx_empty};                    // R18

  // Read multiplexer
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      OFF_MODE:   rd_mux = {19'h0, ir_en_q, 9'h0, pdsel_q, stsel_q};
      OFF_STAT:   rd_mux = {16'h0, stat};
      OFF_RXDATA: rd_mux = {23'h0, rx_head[8:0]};               // R19
      default:    rd_mux = '0;
    endcase
  end

  // Bus answer registers; data is captured before the pop
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (acc)
        prdata <= rd_mux;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ir_en_q  <= FLAG_RST0;
      pdsel_q  <= ISEL_RST;
      stsel_q  <= FLAG_RST0;
      txisel_q <= ISEL_RST;
      txinv_q  <= FLAG_RST0;
      txen_q   <= FLAG_RST0;
      rxisel_q <= ISEL_RST;
      address_detect_enable_q  <= FLAG_RST0;
    end else begin
      if (wr & (paddr == OFF_MODE)) begin
        ir_en_q <= pwdata[B_INFRARED_CODEC_ENABLE];
        pdsel_q <= pwdata[2:1];
        stsel_q <= pwdata[0];
      end
      if (wr_stat) begin
        txisel_q <= {pwdata[B_TXISEL1], pwdata[B_TXISEL0]};   // R4
        txinv_q  <= pwdata[B_TXINV];
        txen_q   <= pwdata[B_TXEN];
        rxisel_q <= pwdata[7:6];
        address_detect_enable_q  <= pwdata[B_ADDRESS_DETECT_ENABLE];
      end
    end
  end

  // Break request: hardware clears at frame end, a fresh write wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      brk_q <= FLAG_RST0;
    else if (wr_stat)
      brk_q <= pwdata[B_TXBRK];
    else if (tx_done & tx_brk_act_q)
      brk_q <= 1'b0;                                         // R6
  end

  // Overrun: a new overflow beats the software clear
  assign rx_clear = wr_stat & ~pwdata[B_OVERRUN_ERROR] & overrun_error_q & ~rx_ovf;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      overrun_error_q <= FLAG_RST0;
    else if (rx_ovf)
      overrun_error_q <= 1'b1;                                        // R17
    else if (rx_clear)
      overrun_error_q <= 1'b0;                                        // R17
  end

  // ****************************************
  // Transmit path
  // ****************************************
  assign tx_push  = wr & (paddr == OFF_TXDATA) & ~tx_full;
  assign tx_flush = wr_stat & txen_q & ~pwdata[B_TXEN];      // R7
  assign tx_pop   = txen_q & (tx_st_q == TX_IDLE) & ~tx_empty;
  assign tx_done  = (tx_st_q == TX_SHIFT) & tick & (tx_sub_q == SUB_LAST) &
                    (tx_left_q == 4'h1);
  assign frame    = usc_frame(pdsel_q, stsel_q, tx_head);

  usc_fifo #(.W(9), .D(FIFO_DEPTH)) u_txq (                  // R21
    .clock   (clock),
    .reset_n (reset_n),
    .flush   (tx_flush),
    .push    (tx_push),
    .din     (pwdata[8:0]),
    .pop     (tx_pop),
    .dout    (tx_head),
    .count   (tx_count),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  // Shifter; a pending break replaces the dummy character it pops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q      <= TX_IDLE;
      tx_vec_q     <= '1;
      tx_left_q    <= '0;
      tx_sub_q     <= '0;
      tx_brk_act_q <= 1'b0;
    end else if (!txen_q) begin
      tx_st_q      <= TX_IDLE;                               // R7
      tx_brk_act_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          if (tx_pop) begin
            tx_st_q      <= TX_SHIFT;
            tx_sub_q     <= '0;
            tx_brk_act_q <= brk_q;
            tx_vec_q     <= brk_q ? 15'h6000 : frame[14:0];  // R6
            tx_left_q    <= brk_q ? BRK_LEN : frame[18:15];
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_sub_q <= 4'(tx_sub_q + 1'b1);
            if (tx_sub_q == SUB_LAST) begin
              tx_vec_q  <= {1'b1, tx_vec_q[14:1]};
              tx_left_q <= 4'(tx_left_q - 1'b1);
              if (tx_left_q == 4'h1)
                tx_st_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pin drive; idle level from polarity bit and codec mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      serial_tx_pin <= 1'b1;
      serial_tx_oe  <= 1'b0;
    end else begin
      serial_tx_pin <= ((tx_st_q == TX_SHIFT) ? tx_vec_q[0] : 1'b1) ^
                       (txinv_q ^ ir_en_q);                  // R5
      serial_tx_oe  <= txen_q;                               // R7
    end
  end

  // Transmit event by selected mode
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      tx_irq <= 1'b0;
    else
      unique case (txisel_q)
        TXI_ANY:   tx_irq <= tx_pop;                         // R1
        TXI_DONE:  tx_irq <= tx_done & tx_empty & ~tx_push;  // R2
        TXI_EMPTY: tx_irq <= tx_pop & (tx_count == 3'h1) &
                             ~tx_push;                       // R3
        default:   tx_irq <= 1'b0;
      endcase
  end

  // ****************************************
  // Receive path
  // ****************************************
  assign nine    = (pdsel_q == PD_9BIT);                     // R20
  assign rx_last = nine ? 4'h9 : ((pdsel_q == 2'h0) ? 4'h8 : 4'h9);
  assign rx_fin  = (rx_st_q == RX_DATA) & tick & (rx_sub_q == SUB_LAST) &
                   (rx_idx_q == rx_last);
  assign rx_keep = ~(address_detect_enable_q & nine & ~rx_sh_q[8]);          // R13
  assign rx_push = rx_fin & rx_keep & ~rx_full & ~overrun_error_q;
  assign rx_ovf  = rx_fin & rx_keep & rx_full;               // R17
  assign rx_pop  = rd & (paddr == OFF_RXDATA) & ~rx_empty;   // R19
  assign rx_next_cnt = 3'(rx_count + 3'(rx_push) - 3'(rx_pop));
  // Error flags travel with the character through the queue
  assign rx_din  = {~serial_rx_pin,                          // R16
                    ~nine & (pdsel_q != 2'h0) &
                    (rx_sh_q[8] != usc_par(pdsel_q, rx_sh_q[7:0])), // R15
                    nine ? rx_sh_q[8] : 1'b0, rx_sh_q[7:0]};

  usc_fifo #(.W(11), .D(FIFO_DEPTH)) u_rxq (
    .clock   (clock),
    .reset_n (reset_n),
    .flush   (rx_clear),                                     // R17
    .push    (rx_push),
    .din     (rx_din),
    .pop     (rx_pop),
    .dout    (rx_head),
    .count   (rx_count),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  // Receive shifter, mid-bit sampling at sixteen ticks per bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q  <= RX_IDLE;
      rx_sub_q <= '0;
      rx_idx_q <= '0;
      rx_sh_q  <= '0;
    end else if (rx_clear) begin
      rx_st_q  <= RX_IDLE;                                   // R17
    end else begin
      unique case (rx_st_q)
        RX_IDLE: begin
          rx_sub_q <= '0;
          rx_idx_q <= '0;
          if (!serial_rx_pin)
            rx_st_q <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rx_sub_q <= 4'(rx_sub_q + 1'b1);
            if (rx_sub_q == SUB_MID) begin
              rx_sub_q <= '0;
              rx_st_q  <= serial_rx_pin ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_sub_q <= 4'(rx_sub_q + 1'b1);
            if (rx_sub_q == SUB_LAST) begin
              rx_idx_q <= 4'(rx_idx_q + 1'b1);
              if (rx_idx_q == rx_last)
                rx_st_q <= RX_IDLE;
              else
                rx_sh_q[rx_idx_q[3:0]] <= serial_rx_pin;
            end
          end
        end
      endcase
    end
  end

  // Receive event by selected threshold
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      rx_irq <= 1'b0;
    else if (!rxisel_q[1])
      rx_irq <= rx_push;                                     // R12
    else if (rxisel_q == RXI_3Q)
      rx_irq <= rx_push & (rx_next_cnt == RX_TH3);           // R11
    else
      rx_irq <= rx_push & (rx_next_cnt == RX_TH4);           // R10
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_load;
    tx_pop && !tx_flush && !wr_stat ##1 tx_st_q == TX_SHIFT;
  endsequence

  a_tx_mode_any: assert property ( // R1
    txisel_q == TXI_ANY && tx_pop |=> tx_irq)
    else $error("transmit event missing on buffer move");
  a_tx_mode_done: assert property ( // R2
    txisel_q == TXI_DONE && tx_irq |-> $past(tx_done) && tx_empty)
    else $error("transmit done event without completion");
  a_tx_mode_empty: assert property ( // R3
    txisel_q == TXI_EMPTY && tx_irq |-> $past(tx_count) == 3'h1 && tx_empty)
    else $error("transmit empty event with buffer not empty");
  a_tx_load_start: assert property ( // R7
    tx_pop && !tx_flush && !wr_stat |-> s_load)
    else $error("shifter did not load popped character");
  a_brk_self_clear: assert property ( // R6
    tx_done && tx_brk_act_q && !wr_stat |=> !brk_q)
    else $error("break request not cleared after break frame");
  a_tx_abort: assert property ( // R7
    tx_flush |=> tx_empty ##1 !serial_tx_oe)
    else $error("transmit disable did not flush and release pin");
  a_rx_full_irq: assert property ( // R10
    rxisel_q == RXI_FULL && rx_irq |-> rx_count == RX_TH4)
    else $error("full threshold event at wrong occupancy");
  a_rx_3q_irq: assert property ( // R11
    rxisel_q == RXI_3Q && rx_irq |-> rx_count == RX_TH3)
    else $error("three-quarter event at wrong occupancy");
  a_rx_any_irq: assert property ( // R12
    !rxisel_q[1] && rx_push |=> rx_irq && !rx_empty)
    else $error("receive event missing on character store");
  a_ovr_flush: assert property ( // R17
    rx_clear |=> !overrun_error_q && rx_empty && rx_st_q == RX_IDLE)
    else $error("overrun clear did not flush receiver");
endmodule : usc_core

// ### dv/usc_line_model.sv
// Remote serial device that drives the receive line of the port.
// Assumes the bench hands it frames already built, start bit first.
`timescale 1ns/1ns
module usc_line_model #(
  parameter int BAUD_DIV = 1
) (
  input  wire logic clock, // System clock
  output logic      line   // Port receive pin
);
  // Idle high, so a released line never looks like a start bit
  initial line = 1'b1;
  // LSB first, one bit per sixteen ticks, one idle bit after each frame
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i <= n; i++) begin
      line <= (i < n) ? bits[i] : 1'b1;
      repeat (16 * BAUD_DIV) @(posedge clock);
    end
  endtask : send
endmodule : usc_line_model

// ### dv/test_uart_status_and_irq_control.sv
// Self-checking bench for the serial port status and control block.
// Assumes a line model on the receive pin and APB access to registers.
`timescale 1ns/1ns
module test_uart_status_and_irq_control;
  import usc_pkg::*;
  localparam int BD = 1;
  localparam logic [7:0] ST = OFF_STAT;
  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, rx_pin, tx_pin, tx_oe, tx_irq, rx_irq;
  int errors = 0, checks_done = 0, cycles = 0;
  int tx_cnt = 0, rx_cnt = 0, run = 0, last_run = 0;

  usc_core #(.BAUD_DIV(BD)) dut (.clock(clock), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin),
    .serial_tx_oe(tx_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
  usc_line_model #(.BAUD_DIV(BD)) lm (.clock(clock), .line(rx_pin));

  always #20 clock = ~clock;
  // Irq pulse counts, low-run length on the line, hang guard
  always @(posedge clock) begin
    cycles++;
    if (tx_irq === 1'b1) tx_cnt++;
    if (rx_irq === 1'b1) rx_cnt++;
    if (tx_pin === 1'b0) run++;
    else begin
      if (run != 0) last_run = run;
      run = 0;
    end
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic summarize();
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Setup, access held until pready, one idle cycle after release
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic txp(input logic [7:0] d, input logic bp, input logic sp);
    lm.send({1'b0, sp, ^d ^ bp, d, 1'b0}, 11);
  endtask : txp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, ST, 32'h0);
    chk(rd, 32'h0110);
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask : t_reset

  task automatic t_pol();
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_MODE, 32'(k[0]) << B_INFRARED_CODEC_ENABLE);
      apb(1'b1, ST, 32'h400 | (32'(k[1]) << B_TXINV));
      repeat (3) @(posedge clock);
      chk(32'(tx_pin), 32'(1 ^ k[0] ^ k[1]));
      chk(32'(tx_oe), 32'h1);
    end
    apb(1'b1, OFF_MODE, 32'h0);
  endtask : t_pol

  // Three queued chars released at once by enable
  task automatic t_txirq();
    for (int k = 0; k < 3; k++) begin
      // Frame shape per pass: 8N1, 8E2, 9-bit
      apb(1'b1, OFF_MODE, 32'(k) * 32'h3);
      apb(1'b1, ST, (k == 1) ? 32'h2000 : (k == 2) ? 32'h8000 : 32'h0);
      for (int j = 0; j < 3; j++) apb(1'b1, OFF_TXDATA, 32'h55 + 32'(j));
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h300, 32'h0);
      tx_cnt = 0;
      apb(1'b1, ST, 32'h400 | ((k == 1) ? 32'h2000 : 32'(k) << 14));
      repeat (600 * BD) @(posedge clock);
      chk(32'(tx_cnt), (k == 0) ? 32'h3 : 32'h1);
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h300, 32'h100);
    end
  endtask : t_txirq

  task automatic t_full();
    apb(1'b1, ST, 32'h0);
    for (int j = 0; j < 5; j++) apb(1'b1, OFF_TXDATA, 32'(j));
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h300, 32'h200);
    apb(1'b1, ST, 32'h400);
    apb(1'b1, ST, 32'h0);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h300, 32'h100);
    chk(32'(tx_oe), 32'h0);
  endtask : t_full

  task automatic t_break();
    last_run = 0;
    apb(1'b1, ST, 32'hc00);
    apb(1'b1, OFF_TXDATA, 32'hff);
    repeat (300 * BD) @(posedge clock);
    chk(32'(last_run), 32'(13 * 16 * BD));
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h800, 32'h0);
    apb(1'b1, ST, 32'h0);
  endtask : t_break

  // Thresholds seen after three and after four received chars
  task automatic t_rxirq();
    // Odd parity, so the parity slot of each frame is really expected
    apb(1'b1, OFF_MODE, 32'h4);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, ST, (k == 0) ? 32'h0 : 32'h40 + 32'(k) * 32'h40);
      rx_cnt = 0;
      for (int j = 0; j < 3; j++) txp(8'h30 + 8'(j), 1'b1, 1'b1);
      chk(32'(rx_cnt), 32'(k == 0 ? 3 : k == 1 ? 1 : 0));
      txp(8'h33, 1'b1, 1'b1);
      chk(32'(rx_cnt), 32'(k == 0 ? 4 : 1));
      for (int j = 0; j < 4; j++) begin
        apb(1'b0, ST, 32'h0);
        chk(rd & 32'hd, 32'h1);
        apb(1'b0, OFF_RXDATA, 32'h0);
        chk(rd & 32'h1ff, 32'h30 + 32'(j));
      end
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h1, 32'h0);
    end
  endtask : t_rxirq

  task automatic t_overrun();
    for (int j = 0; j < 5; j++) txp(8'(j), 1'b1, 1'b1);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b1, ST, 32'h0);
    apb(1'b0, ST, 32'h0);
    chk(rd, 32'h0110);
  endtask : t_overrun

  task automatic t_addr();
    apb(1'b1, OFF_MODE, 32'h6);
    apb(1'b1, ST, 32'h20);
    lm.send(12'({1'b1, 9'h055, 1'b0}), 11);
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h1, 32'h0);
    fork
      lm.send(12'({1'b1, 9'h1a5, 1'b0}), 11);
      begin
        repeat (80 * BD) @(posedge clock);
        apb(1'b0, ST, 32'h0);
        chk(rd & 32'h10, 32'h0);
      end
    join
    apb(1'b0, ST, 32'h0);
    chk(rd & 32'h11, 32'h11);
    apb(1'b0, OFF_RXDATA, 32'h0);
    chk(rd & 32'h1ff, 32'h1a5);
  endtask : t_addr

  // Bad parity, clean, bad stop: flags must follow the head
  task automatic t_err();
    apb(1'b1, OFF_MODE, 32'h2);
    apb(1'b1, ST, 32'h0);
    txp(8'h31, 1'b1, 1'b1);
    txp(8'h42, 1'b0, 1'b1);
    txp(8'h53, 1'b0, 1'b0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'hc, 32'(j == 0 ? 8 : j == 2 ? 4 : 0));
      apb(1'b0, OFF_RXDATA, 32'h0);
      chk(rd & 32'h1ff, 32'h31 + 32'h11 * 32'(j));
    end
  endtask : t_err

  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_pol();
    t_txirq();
    t_full();
    t_break();
    t_rxirq();
    t_overrun();
    t_addr();
    t_err();
    summarize();
  end
endmodule : test_uart_status_and_irq_control
